// ==== rtl/startup_clock_reset_config.sv ====
// start-up reset sequencer: straps, pll lock wait, dual-use reset pin
// How it works
// - clock-ratio straps pick start-up core ratio
// - software may rewrite pll multiplier and divider
// - wait 4096 input clocks for pll lock
// - then core runs from reset vector
// - dual pin defaults to reset output
// - control bit 0 selects running-reset input
//
// Decided for this implementation: the placing of the registers and the plain strobed port.
`timescale 1ns/100ps
module startup_clock_reset_config
    import startup_pkg::*;
#(
    parameter int LOCK_COUNT = LOCK_CYCLES
) (
    // clock and hardware reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // straps
    input wire logic [1:0] clk_ratio_strap,
    input wire logic [2:0] boot_strap,
    // software reset request (pulse)
    input wire logic soft_reset,
    // dual-function reset pin, active low on the wire
    input wire logic reset_pin_in,
    output logic reset_pin_out,
    output logic reset_pin_oe,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // core side
    output logic core_run,
    output logic [23:0] core_start_addr,
    output logic [5:0] pll_mult,
    output logic [1:0] pll_div,
    output logic [2:0] boot_mode,
    output logic ratio_reserved
);
    typedef enum {ST_RESET, ST_LOCK, ST_RUN} phase_t;

    typedef struct packed {
        phase_t phase;
        logic core_run;
        logic [5:0] mult;
        logic [1:0] div;
        logic [2:0] boot;
        logic rsvd;
        logic run_rst_en;
        logic [2:0] low_cnt;
        logic pin_out;
        logic pin_oe;
        logic [15:0] rdata;
        logic timer_restart;
        logic [23:0] start_addr;
        // only the lock-span assertion reads this count
        logic [LOCK_W-1:0] lock_span;
    } regs_t;

    regs_t r;
    regs_t next_r;
    logic lock_done;

    function automatic logic [5:0] strap_ratio(input logic [1:0] code);
        case (code)
            RATIO_CODE_8: strap_ratio = RATIO_8;
            RATIO_CODE_32: strap_ratio = RATIO_32;
            RATIO_CODE_16: strap_ratio = RATIO_16;
            default: strap_ratio = RATIO_8;
        endcase
    endfunction : strap_ratio

    lock_timer #(
        .LOCK_COUNT(LOCK_COUNT)
    ) u_lock (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .restart(r.timer_restart),
        .done(lock_done)
    );

    always_comb begin
        logic run_rst_hit;
        run_rst_hit = 1'b0;
        next_r = r;
        next_r.timer_restart = 1'b0;
        next_r.rdata = '0;
        // saturate so a stuck lock wait cannot wrap the count
        if (r.phase == ST_LOCK) begin
            if (r.lock_span != '1) begin
                next_r.lock_span = r.lock_span + LOCK_W'(1);
            end
        end else begin
            next_r.lock_span = '0;
        end
        // count low samples of the running-reset input
        // low width check
        if (r.run_rst_en && r.phase == ST_RUN && !reset_pin_in) begin
            if (r.low_cnt != RUN_RST_MIN) begin
                next_r.low_cnt = r.low_cnt + 3'h1;
            end
        end else begin
            next_r.low_cnt = '0;
        end
        // reset taken on the rising edge of the pin after a valid low
        run_rst_hit = r.run_rst_en && reset_pin_in && r.low_cnt == RUN_RST_MIN;
        case (r.phase)
            ST_RESET: begin
                next_r.mult = strap_ratio(clk_ratio_strap);
                next_r.div = DIV_RESET;
                next_r.rsvd = clk_ratio_strap == RATIO_CODE_RSVD;
                next_r.boot = boot_strap;
                next_r.timer_restart = 1'b1;
                next_r.phase = ST_LOCK;
            end
            ST_LOCK: begin
                if (lock_done && !r.timer_restart) begin
                    next_r.phase = ST_RUN;
                    next_r.core_run = 1'b1;
                    next_r.start_addr = RESET_VECTOR;
                end
            end
            ST_RUN: begin
                if (soft_reset || run_rst_hit) begin
                    next_r.boot = boot_strap;
                    next_r.core_run = 1'b0;
                    next_r.timer_restart = 1'b1;
                    next_r.phase = ST_LOCK;
                end
            end
            default: next_r.phase = ST_RESET;
        endcase
        if (reg_wr) begin
            case (reg_addr)
                ADDR_PWR_MGMT: begin
                    if (r.core_run) begin
                        next_r.mult = reg_wdata[PM_MULT_LSB +: MULT_W];
                        next_r.div = reg_wdata[PM_DIV_MSB:PM_DIV_LSB];
                    end
                end
                ADDR_RUN_RST_CTL: begin
                    next_r.run_rst_en = reg_wdata[RUN_RST_EN_BIT];
                end
                default: ;
            endcase
        end
        if (reg_rd) begin
            case (reg_addr)
                ADDR_PWR_MGMT: next_r.rdata = {6'h00, r.div, 2'h0, r.mult};
                ADDR_RUN_RST_CTL: next_r.rdata = {15'h0000, r.run_rst_en};
                ADDR_STATUS: next_r.rdata = {11'h000, r.rsvd, r.boot, r.core_run};
                default: next_r.rdata = '0;
            endcase
        end
        // output function unless enabled as input
        next_r.pin_oe = !next_r.run_rst_en;
        next_r.pin_out = next_r.core_run;
    end

    always_ff @(posedge ref_clk) begin
        // reset held is the board's duty
        if (!rst_b) begin
            r <= '{phase: ST_RESET, core_run: 1'b0, mult: RATIO_8, div: DIV_RESET,
                   boot: 3'h0, rsvd: 1'b0, run_rst_en: 1'b0, low_cnt: 3'h0,
                   pin_out: 1'b0, pin_oe: 1'b1, rdata: 16'h0000, timer_restart: 1'b0,
                   start_addr: RESET_VECTOR, lock_span: '0};
        end else begin
            r <= next_r;
        end
    end

    assign reset_pin_out = r.pin_out;
    assign reset_pin_oe = r.pin_oe;
    assign reg_rdata = r.rdata;
    assign core_run = r.core_run;
    assign core_start_addr = r.start_addr;
    assign pll_mult = r.mult;
    assign pll_div = r.div;
    assign boot_mode = r.boot;
    assign ratio_reserved = r.rsvd;

    property p_strap_ratio;
        @(posedge ref_clk) disable iff (!rst_b)
        rst_b && r.phase == ST_RESET |=> pll_mult == strap_ratio($past(clk_ratio_strap));
    endproperty
    a_strap_ratio: assert property (p_strap_ratio) else $error("bad start ratio");

    sequence s_lock_start;
        r.phase == ST_LOCK && r.timer_restart;
    endsequence
    property p_no_early_run;
        @(posedge ref_clk) disable iff (!rst_b)
        s_lock_start |-> !core_run [*8];
    endproperty
    a_no_early_run: assert property (p_no_early_run) else $error("core ran early");

    property p_lock_span;
        @(posedge ref_clk) disable iff (!rst_b)
        $rose(core_run) |-> r.lock_span >= LOCK_W'(LOCK_COUNT);
    endproperty
    a_lock_span: assert property (p_lock_span) else $error("lock wait too short");

    property p_run_vector;
        @(posedge ref_clk) disable iff (!rst_b)
        $rose(core_run) |-> core_start_addr == RESET_VECTOR;
    endproperty
    a_run_vector: assert property (p_run_vector) else $error("wrong start address");

    property p_pin_default;
        @(posedge ref_clk) disable iff (!rst_b)
        !r.run_rst_en |-> reset_pin_oe;
    endproperty
    a_pin_default: assert property (p_pin_default) else $error("pin not output");

    property p_ctl_bit;
        @(posedge ref_clk) disable iff (!rst_b)
        reg_wr && reg_addr == ADDR_RUN_RST_CTL |=> ##1 reset_pin_oe == !$past(reg_wdata[0], 2);
    endproperty
    a_ctl_bit: assert property (p_ctl_bit) else $error("pin select wrong");

    property p_out_tracks;
        @(posedge ref_clk) disable iff (!rst_b)
        reset_pin_oe |-> reset_pin_out == core_run;
    endproperty
    a_out_tracks: assert property (p_out_tracks) else $error("reset out wrong");

    property p_pll_write;
        @(posedge ref_clk) disable iff (!rst_b)
        reg_wr && reg_addr == ADDR_PWR_MGMT && core_run |=> pll_mult == $past(reg_wdata[5:0]);
    endproperty
    a_pll_write: assert property (p_pll_write) else $error("pll write lost");

    property p_short_run_rst;
        @(posedge ref_clk) disable iff (!rst_b)
        core_run && r.low_cnt < RUN_RST_MIN && !soft_reset |=> core_run;
    endproperty
    a_short_run_rst: assert property (p_short_run_rst) else $error("short pulse reset");
endmodule : startup_clock_reset_config

// ==== inc/startup_pkg.sv ====
// constants for the start-up clock and reset configuration block
package startup_pkg;
    // clock-ratio strap encodings and ratios
    localparam logic [1:0] RATIO_CODE_8 = 2'h0;
    localparam logic [1:0] RATIO_CODE_32 = 2'h1;
    localparam logic [1:0] RATIO_CODE_16 = 2'h2;
    localparam logic [1:0] RATIO_CODE_RSVD = 2'h3;
    localparam logic [5:0] RATIO_8 = 6'h08;
    localparam logic [5:0] RATIO_16 = 6'h10;
    localparam logic [5:0] RATIO_32 = 6'h20;
    // pll multiplier and divider field widths
    localparam int MULT_W = 6;
    localparam int DIV_W = 2;
    // pll lock interval in input-clock cycles
    localparam int LOCK_CYCLES = 4096;
    localparam int LOCK_W = 13;
    // register index map on the plain register port
    localparam logic [3:0] ADDR_PWR_MGMT = 4'h0;
    localparam logic [3:0] ADDR_RUN_RST_CTL = 4'h1;
    localparam logic [3:0] ADDR_STATUS = 4'h2;
    // field positions
    localparam int RUN_RST_EN_BIT = 0;
    localparam int PM_MULT_LSB = 0;
    localparam int PM_DIV_LSB = 8;
    localparam int PM_DIV_MSB = 9;
    // default divider value after reset
    localparam logic [1:0] DIV_RESET = 2'h0;
    // reset vector, arbitrary neutral value
    localparam logic [23:0] RESET_VECTOR = 24'h080000;
    // running-reset minimum low width in input clocks, sampled by the device
    localparam logic [2:0] RUN_RST_MIN = 3'h4;
endpackage : startup_pkg

// ==== rtl/lock_timer.sv ====
// counter that times the pll lock interval
`timescale 1ns/100ps
module lock_timer
    import startup_pkg::*;
#(
    parameter int LOCK_COUNT = LOCK_CYCLES
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // control
    input wire logic restart,
    output logic done
);
    typedef struct packed {
        logic [LOCK_W-1:0] cnt;
        logic done;
    } timer_t;

    timer_t state;
    timer_t next_state;

    always_comb begin
        next_state = state;
        if (restart) begin
            next_state.cnt = '0;
            next_state.done = 1'b0;
        end else if (!state.done) begin
            if (state.cnt == LOCK_W'(LOCK_COUNT - 1)) begin
                next_state.done = 1'b1;
            end else begin
                next_state.cnt = state.cnt + LOCK_W'(1);
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign done = state.done;
endmodule : lock_timer

// ==== tb/board_model.sv ====
// board side of the dual reset pin: pull-up plus a running-reset pulse source
`timescale 1ns/100ps
module board_model (
    // clock
    input wire logic ref_clk,
    // pulse request from the bench
    input wire logic pulse_go,
    input wire logic [3:0] pulse_len,
    // device side of the pin
    input wire logic dev_out,
    input wire logic dev_oe,
    output logic pin_level
);
    logic [3:0] low_cnt = 4'h0;
    always @(posedge ref_clk) begin
        if (pulse_go) begin
            low_cnt <= pulse_len;
        end else if (low_cnt != 4'h0) begin
            low_cnt <= low_cnt - 4'h1;
        end
    end
    // pull-up wins when nobody drives, so a released pin never keeps a stale low
    assign pin_level = dev_oe ? dev_out : (low_cnt == 4'h0);
endmodule : board_model

// ==== tb/startup_clock_reset_config_test.sv ====
// self-checking bench for the start-up clock and reset block
`timescale 1ns/100ps
module startup_clock_reset_config_test;
    import startup_pkg::*;
    localparam int LC = 16;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [1:0] clk_ratio_strap = 2'h0;
    logic [2:0] boot_strap = 3'h0;
    logic soft_reset = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic pulse_go = 1'b0;
    logic [3:0] pulse_len = 4'h0;
    logic reset_pin_in, reset_pin_out, reset_pin_oe, core_run, ratio_reserved;
    logic [15:0] reg_rdata, d;
    logic [23:0] core_start_addr;
    logic [5:0] pll_mult, m;
    logic [1:0] pll_div, dv;
    logic [2:0] boot_mode, bs;
    int err_count = 0;
    int check_count = 0;
    int n;
    always #2.5 ref_clk = ~ref_clk;
    startup_clock_reset_config #(.LOCK_COUNT(LC)) u_dut (.ref_clk(ref_clk), .rst_b(rst_b),
        .clk_ratio_strap(clk_ratio_strap), .boot_strap(boot_strap), .soft_reset(soft_reset),
        .reset_pin_in(reset_pin_in), .reset_pin_out(reset_pin_out),
        .reset_pin_oe(reset_pin_oe), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .core_run(core_run),
        .core_start_addr(core_start_addr), .pll_mult(pll_mult), .pll_div(pll_div),
        .boot_mode(boot_mode), .ratio_reserved(ratio_reserved));
    board_model u_board (.ref_clk(ref_clk), .pulse_go(pulse_go), .pulse_len(pulse_len),
        .dev_out(reset_pin_out), .dev_oe(reset_pin_oe), .pin_level(reset_pin_in));
    task results;
        if (err_count == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : results
    task chk(input logic [23:0] got, input logic [23:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    function logic [5:0] ratio_of(input logic [1:0] c);
        case (c)
            RATIO_CODE_32: ratio_of = RATIO_32;
            RATIO_CODE_16: ratio_of = RATIO_16;
            default: ratio_of = RATIO_8;
        endcase
    endfunction : ratio_of
    task wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task rd(input logic [3:0] a, output logic [15:0] v);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask : rd
    // edges counted from the call, with start as the count already reached
    task wait_run(input int start);
        n = start;
        while (core_run !== 1'b1 && n < LC + 20) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        chk(24'(n >= LC && n <= LC + 6), 24'h1);
        chk(core_start_addr, RESET_VECTOR);
        chk(reset_pin_out, 24'h1);
    endtask : wait_run
    task do_reset(input logic [1:0] code);
        @(posedge ref_clk);
        clk_ratio_strap <= code;
        boot_strap <= 3'($urandom);
        @(posedge ref_clk);
        rst_b <= 1'b0;
        // reset held well past four clocks
        repeat (20) @(posedge ref_clk);
        #1 chk({core_run, reset_pin_oe, reset_pin_out}, 24'h2);
        @(posedge ref_clk);
        rst_b <= 1'b1;
        // a power write while halted must not stick
        wr(ADDR_PWR_MGMT, 16'h033f);
        wait_run(2);
        chk(pll_mult, ratio_of(code));
        chk(pll_div, DIV_RESET);
        chk(ratio_reserved, 24'(code == RATIO_CODE_RSVD));
        chk(boot_mode, boot_strap);
    endtask : do_reset
    task pulse(input logic [3:0] len, input logic exp_run);
        @(posedge ref_clk);
        pulse_len <= len;
        pulse_go <= 1'b1;
        @(posedge ref_clk);
        pulse_go <= 1'b0;
        repeat (8) @(posedge ref_clk);
        #1 chk(core_run, exp_run);
        if (!exp_run) begin
            wait_run(0);
        end
    endtask : pulse
    initial begin
        repeat (5000) @(posedge ref_clk);
        err_count++;
        results();
    end
    initial begin
        void'($urandom(32'ha9c1728f));
        for (int c = 0; c < 4; c++) begin
            do_reset(2'(c));
        end
        rd(ADDR_RUN_RST_CTL, d);
        chk(d, 24'h0);
        chk(reset_pin_oe, 24'h1);
        rd(ADDR_STATUS, d);
        chk(d, {19'h0, 1'b1, boot_strap, 1'b1});
        repeat (4) begin
            m = 6'($urandom);
            dv = 2'($urandom);
            wr(ADDR_PWR_MGMT, {6'h0, dv, 2'h0, m});
            rd(ADDR_PWR_MGMT, d);
            chk(d, {14'h0, dv, 2'h0, m});
            chk({pll_div, pll_mult}, {dv, m});
        end
        // unmapped index: write dropped, read gives zero
        wr(4'hf, 16'hffff);
        rd(4'hf, d);
        chk(d, 24'h0);
        chk(pll_mult, m);
        // valid-length pulse while still a reset output must do nothing
        pulse(4'h5, 1'b1);
        wr(ADDR_RUN_RST_CTL, 16'h0001);
        rd(ADDR_RUN_RST_CTL, d);
        chk(d, 24'h1);
        chk(reset_pin_oe, 24'h0);
        pulse(4'h3, 1'b1);
        pulse(4'h5, 1'b0);
        bs = boot_mode;
        @(posedge ref_clk);
        boot_strap <= ~boot_strap;
        @(posedge ref_clk);
        #1 chk(boot_mode, bs);
        @(posedge ref_clk);
        soft_reset <= 1'b1;
        @(posedge ref_clk);
        soft_reset <= 1'b0;
        repeat (2) @(posedge ref_clk);
        #1 chk(core_run, 24'h0);
        wait_run(0);
        chk(boot_mode, boot_strap);
        // hardware reset must hand the pin back to its output role
        do_reset(2'($urandom));
        chk(reset_pin_oe, 24'h1);
        results();
    end
endmodule : startup_clock_reset_config_test
